// ---- core/eil_ext_int_latch.v ----
`timescale 1ns/10ps
`include "eil_map.vh"
// Overview of operation
// [RQ1] pin going low latches a request, per the selected sensitivity
// [RQ2] vector fetch acknowledge pulse clears the request latch
// [RQ3] writing 1 to the acknowledge bit clears the latch, break permitting
// [RQ4] reset clears latch and sensitivity bit even with pin held low
// [RQ5] sensitivity bit: 1 edge plus level, 0 edge only; read/write, reset 0
// [RQ6] edge-only mode: acknowledge clears latch at once regardless of pin
// [RQ7] edge-plus-level: clear needs acknowledge and pin high, either order
// [RQ8] edge-plus-level: request stays pending while the pin is low
// [RQ9] falling edge after an acknowledge write latches a new request
// [RQ10] acknowledge bit is write-only, reads 0, reset clears it
// [RQ11] latched request reaches priority logic only while mask bit clear
// [RQ12] mask bit read/write: 1 disables, 0 enables, reset clears
// [RQ13] pending flag reads 1 when a request is pending, ignoring mask
// [RQ14] taken request fetches the vector pair at FFFA and FFFB
// [RQ15] in break, software acknowledge clears only with break clear enable 1
// [RQ16] break clear enable 0: acknowledge writes in break change nothing
// [RQ17] current pin level is given to the CPU for branch tests
// [RQ18] falling edge is a high sample followed by a low sample
module eil_ext_int_latch (
  input wire sys_clk, // bus clock
  input wire rst, // synchronous reset, active high
  input wire ext_int_n, // external interrupt pin, active low, asynchronous
  input wire vector_fetch_ack, // one-cycle pulse: cpu fetched this vector
  input wire break_state, // cpu is in break state
  input wire break_clear_enable, // allows software clear during break
  input wire [3:0] reg_addr, // register address
  input wire [7:0] reg_wdata, // register write data
  input wire reg_wr, // write strobe
  input wire reg_rd, // read strobe
  output reg [7:0] reg_rdata, // read data, valid the cycle after reg_rd
  output reg irq_to_cpu, // request to the priority logic
  output reg [15:0] vector_addr_hi, // vector high byte address
  output reg [15:0] vector_addr_lo, // vector low byte address
  output reg branch_if_pin_high, // synchronised pin level, 1 means high
  output reg irq_out // level interrupt from sticky event bits
);

  reg pin_meta_reg;
  reg pin_sync_reg;
  reg pin_prev_reg;
  reg [2:0] fill_reg;
  reg latch_reg;
  reg latch_next;
  reg mode_reg;
  reg mask_reg;
  reg [1:0] ev_status_reg;
  reg [1:0] ev_status_next;
  reg [1:0] ev_mask_reg;
  reg [7:0] rdata_next;

  wire fall_edge;
  wire sw_ack;
  wire ack_any;
  wire wr_ctrl;
  wire wr_evs;
  wire wr_evm;
  wire pending;

  // pin passes three flops; logic reads the second and third, never the first
  always @(posedge sys_clk) begin
    if (rst) begin
      pin_meta_reg <= 1'b1;
      pin_sync_reg <= 1'b1;
      pin_prev_reg <= 1'b1;
      fill_reg <= 3'h0;
    end else begin
      pin_meta_reg <= ext_int_n;
      pin_sync_reg <= pin_meta_reg;
      pin_prev_reg <= pin_sync_reg;
      fill_reg <= {fill_reg[1:0], 1'b1};
    end
  end

  // no edge until both samples are real: a pin held low through reset is not a request
  assign fall_edge = fill_reg[2] & pin_prev_reg & ~pin_sync_reg; // [RQ18] [RQ4]
  assign wr_ctrl = reg_wr && (reg_addr == `EIL_ADDR_STATUS_CONTROL);
  assign wr_evs = reg_wr && (reg_addr == `EIL_ADDR_INT_STATUS);
  assign wr_evm = reg_wr && (reg_addr == `EIL_ADDR_INT_MASK);
  // software ack gated in break unless the break clear enable is set
  assign sw_ack = wr_ctrl && reg_wdata[`EIL_BIT_ACK] && (!break_state || break_clear_enable); // [RQ3] [RQ15] [RQ16]
  assign ack_any = vector_fetch_ack | sw_ack; // [RQ2]
  // level mode keeps the request alive while the pin sits low
  // an ack taken while low is not lost: only the pin term remains, so either order clears
  assign pending = latch_reg | (mode_reg & ~pin_sync_reg); // [RQ7] [RQ8]

  always @* begin
    latch_next = latch_reg;
    if (ack_any) begin
      latch_next = 1'b0; // [RQ6]
    end
    // an edge in the ack cycle wins, so a new request is never lost
    if (fall_edge) begin
      latch_next = 1'b1; // [RQ1] [RQ9]
    end
  end

  always @(posedge sys_clk) begin
    if (rst) begin
      latch_reg <= 1'b0; // [RQ4]
      mode_reg <= 1'b0; // [RQ4] [RQ5]
      mask_reg <= 1'b0; // [RQ12]
    end else begin
      latch_reg <= latch_next;
      if (wr_ctrl) begin
        mode_reg <= reg_wdata[`EIL_BIT_MODE]; // [RQ5]
        mask_reg <= reg_wdata[`EIL_BIT_MASK]; // [RQ12]
      end
    end
  end

  always @* begin
    ev_status_next = ev_status_reg;
    if (wr_evs) begin
      ev_status_next = ev_status_reg & ~reg_wdata[1:0];
    end
    // set beats a simultaneous clear
    if (latch_next && !latch_reg) begin
      ev_status_next[`EIL_EV_LATCHED] = 1'b1;
    end
    if (!latch_next && latch_reg) begin
      ev_status_next[`EIL_EV_CLEARED] = 1'b1;
    end
  end

  always @* begin
    rdata_next = 8'h00;
    case (reg_addr)
      `EIL_ADDR_STATUS_CONTROL: begin
        rdata_next[`EIL_BIT_MODE] = mode_reg;
        rdata_next[`EIL_BIT_MASK] = mask_reg;
        rdata_next[`EIL_BIT_ACK] = 1'b0; // [RQ10]
        rdata_next[`EIL_BIT_PENDING] = pending; // [RQ13]
      end
      `EIL_ADDR_INT_STATUS: rdata_next[1:0] = ev_status_reg;
      `EIL_ADDR_INT_MASK: rdata_next[1:0] = ev_mask_reg;
      default: rdata_next = 8'h00;
    endcase
  end

  always @(posedge sys_clk) begin
    if (rst) begin
      ev_status_reg <= 2'h0;
      ev_mask_reg <= 2'h0;
      reg_rdata <= 8'h00;
      irq_to_cpu <= 1'b0;
      vector_addr_hi <= `EIL_VEC_HI;
      vector_addr_lo <= `EIL_VEC_LO;
      branch_if_pin_high <= 1'b1;
      irq_out <= 1'b0;
    end else begin
      ev_status_reg <= ev_status_next;
      if (wr_evm) begin
        ev_mask_reg <= reg_wdata[1:0];
      end
      reg_rdata <= reg_rd ? rdata_next : 8'h00;
      irq_to_cpu <= pending & ~mask_reg; // [RQ11]
      vector_addr_hi <= `EIL_VEC_HI; // [RQ14]
      vector_addr_lo <= `EIL_VEC_LO; // [RQ14]
      branch_if_pin_high <= pin_sync_reg; // [RQ17]
      irq_out <= |(ev_status_next & ev_mask_reg);
    end
  end

endmodule // eil_ext_int_latch

// ---- core/eil_map.vh ----
`ifndef EIL_MAP_VH
`define EIL_MAP_VH
// register indices on the plain register port
`define EIL_ADDR_STATUS_CONTROL 4'h0
`define EIL_ADDR_INT_STATUS 4'h1
`define EIL_ADDR_INT_MASK 4'h2
// status/control bit positions
`define EIL_BIT_MODE 0
`define EIL_BIT_MASK 1
`define EIL_BIT_ACK 2
`define EIL_BIT_PENDING 3
// event status bit positions
`define EIL_EV_LATCHED 0
`define EIL_EV_CLEARED 1
// reset values
`define EIL_RST_CTRL 8'h00
`define EIL_RST_REQUEST_MASK_BIT 8'h00
// vector pair addresses
`define EIL_VEC_HI 16'hFFFA
`define EIL_VEC_LO 16'hFFFB
`endif

// ---- sim/eil_pin_src.sv ----
`timescale 1ns/10ps
module eil_pin_src (
  input wire pull_low, // source holds the pin low
  output wire ext_int_n // pullup when released
);
  assign ext_int_n = ~pull_low;
endmodule // eil_pin_src

// ---- sim/eil_ext_int_latch_monitor.sv ----
`timescale 1ns/10ps
module eil_monitor (
  input wire logic sys_clk, // bus clock
  input wire logic rst, // synchronous reset
  input wire logic ext_int_n, // interrupt pin
  input wire logic vector_fetch_ack, // vector fetch pulse
  input wire logic reg_wr, // write strobe
  input wire logic reg_rd, // read strobe
  input wire logic irq_to_cpu, // request to priority logic
  input wire logic branch_if_pin_high, // pin level
  input wire logic irq_out, // event interrupt
  input wire logic [3:0] reg_addr, // register address
  input wire logic [7:0] reg_wdata, // write data
  input wire logic [7:0] reg_rdata, // read data
  input wire logic [15:0] vector_addr_hi, // vector high address
  input wire logic [15:0] vector_addr_lo // vector low address
);
  logic m, mo; // shadow mask and mode
  always @(posedge sys_clk)
    if (rst) {m, mo} <= 2'b00;
    else if (reg_wr && reg_addr == 4'h0) {m, mo} <= reg_wdata[1:0];
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  a_vec_pair: assert property (vector_addr_hi == 16'hFFFA && vector_addr_lo == 16'hFFFB)
    else $error("vector");
  a_ctl_read: assert property (reg_rd && reg_addr == 4'h0 |=> reg_rdata[2:0] == {1'b0, m, mo})
    else $error("ctl");
  a_idle_zero: assert property (!(reg_rd && reg_addr < 4'h3) |=> reg_rdata == 8'h00)
    else $error("idle");
  a_mask_gate: assert property (m |=> !irq_to_cpu)
    else $error("mask");
  a_pin_low: assert property (!ext_int_n [*4] |-> !branch_if_pin_high)
    else $error("pin");
  a_edge_take: assert property (
    !m && $fell(ext_int_n) ##1 (!ext_int_n && !m && !vector_fetch_ack && !reg_wr) [*4] |-> irq_to_cpu)
    else $error("take");
  a_edge_clear: assert property (
    (!mo && !ext_int_n) [*5] ##0 (vector_fetch_ack && !reg_wr) |=> ##1 !irq_to_cpu) else $error("clear");
  a_level_hold: assert property ((mo && !m && !ext_int_n) [*6] |-> irq_to_cpu)
    else $error("level");
  c_irq: cover property (irq_to_cpu);
  c_evt: cover property (irq_out);
  c_lvl: cover property (mo && vector_fetch_ack);
endmodule // eil_monitor
bind eil_ext_int_latch eil_monitor mon_u (.*);

// ---- sim/tb_external_interrupt_latch.sv ----
`timescale 1ns/10ps
`define CHK(n,e,v) begin #1 checks_done++; if ((v)!==(e)) begin failures++; $display("[FAIL] %s exp %h got %h",n,e,v); end end
module tb_external_interrupt_latch;
  logic sys_clk = 0, rst = 1, pull_low = 0, vector_fetch_ack = 0, break_state = 0, break_clear_enable = 0;
  logic reg_wr = 0, reg_rd = 0;
  logic [3:0] reg_addr = 4'h0;
  logic [7:0] reg_wdata = 8'h00;
  wire [7:0] reg_rdata;
  wire [15:0] vector_addr_hi, vector_addr_lo;
  wire ext_int_n, irq_to_cpu, branch_if_pin_high, irq_out;
  int failures = 0, checks_done = 0;
  always #12.5 sys_clk = ~sys_clk;
  eil_pin_src src_u (.*);
  eil_ext_int_latch dut_u (.*);
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    {reg_addr, reg_wdata, reg_wr} <= {a, d, 1'b1};
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    @(posedge sys_clk);
    {reg_addr, reg_rd} <= {a, 1'b1};
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    `CHK("rdata", e, reg_rdata)
  endtask
  // sync plus edge stage needs four edges before the flag shows
  task automatic pin(input logic lo, input int n);
    @(posedge sys_clk);
    pull_low <= lo;
    repeat (n) @(posedge sys_clk);
  endtask
  task automatic close_out;
    if (failures == 0 && checks_done > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    repeat (2) @(posedge sys_clk);
    rst <= 1'b0;
    rd(4'h7, 8'h00);
    wr(4'h0, 8'h06);
    rd(4'h0, 8'h02);
    pin(1, 6);
    rd(4'h0, 8'h0A);
    `CHK("irq", 1'b0, irq_to_cpu)
    wr(4'h0, 8'h00);
    pin(1, 2);
    `CHK("irq", 1'b1, irq_to_cpu)
    `CHK("pin", 1'b0, branch_if_pin_high)
    // one-cycle fetch pulse
    @(posedge sys_clk);
    vector_fetch_ack <= 1'b1;
    @(posedge sys_clk);
    vector_fetch_ack <= 1'b0;
    repeat (2) @(posedge sys_clk);
    `CHK("irq", 1'b0, irq_to_cpu)
    rd(4'h1, 8'h03);
    `CHK("evt", 1'b0, irq_out)
    wr(4'h2, 8'h01);
    pin(1, 1);
    `CHK("evt", 1'b1, irq_out)
    wr(4'h1, 8'h03);
    pin(1, 1);
    `CHK("evt", 1'b0, irq_out)
    pin(0, 4);
    wr(4'h0, 8'h04);
    pin(1, 6);
    rd(4'h0, 8'h08);
    @(posedge sys_clk);
    break_state <= 1'b1;
    wr(4'h0, 8'h04);
    rd(4'h0, 8'h08);
    @(posedge sys_clk);
    break_clear_enable <= 1'b1;
    wr(4'h0, 8'h04);
    break_state <= 1'b0;
    rd(4'h0, 8'h00);
    wr(4'h0, 8'h01);
    rd(4'h0, 8'h09);
    pin(0, 6);
    rd(4'h0, 8'h01);
    `CHK("pin", 1'b1, branch_if_pin_high)
    // level mode: ack while low, then release
    pin(1, 6);
    wr(4'h0, 8'h05);
    rd(4'h0, 8'h09);
    pin(0, 6);
    rd(4'h0, 8'h01);
    // level mode: release first, then ack
    pin(1, 6);
    pin(0, 6);
    rd(4'h0, 8'h09);
    wr(4'h0, 8'h05);
    rd(4'h0, 8'h01);
    pin(1, 6);
    rst <= 1'b1;
    pin(1, 2);
    rst <= 1'b0;
    rd(4'h0, 8'h00);
    pin(1, 4);
    rd(4'h0, 8'h00);
    `CHK("vec_hi", 16'hFFFA, vector_addr_hi)
    `CHK("vec_lo", 16'hFFFB, vector_addr_lo)
    close_out;
  end
endmodule // tb_external_interrupt_latch
